//--- design/sub_swap_defines.svh
// constants for the subtract and nibble exchange datapath slice
// included by the package and the design modules
`ifndef SUB_SWAP_DEFINES_SVH
`define SUB_SWAP_DEFINES_SVH
`define DATA_WIDTH      8
`define NIBBLE_WIDTH    4
`define WORK_RESET      8'h00
`define FLAG_RESET      4'h0
// status flag bit positions inside the four-bit flag vector
`define FLAG_NOBORROW   0
`define FLAG_HALF       1
`define FLAG_ZERO       2
`define FLAG_RANGE      3
`define FLAG_COUNT      4
// memory of the slice: depth in bytes and address width
`define MEM_DEPTH       256
`define MEM_ADDR_WIDTH  8
`endif

//--- design/sub_swap_pkg.sv
// types shared by the datapath slice files
// assumes sub_swap_defines.svh is on the include path
`include "sub_swap_defines.svh"
package sub_swap_pkg;
    typedef logic [`DATA_WIDTH-1:0]     byte_t;
    typedef logic [`MEM_ADDR_WIDTH-1:0] addr_t;
    typedef logic [`FLAG_COUNT-1:0]     flags_t;
    typedef enum logic [3:0]
    {
        OP_NONE         = 4'h0,
        OP_SUB_TO_WORK  = 4'h1,
        OP_SUB_TO_MEM   = 4'h2,
        OP_SUB_IMM      = 4'h3,
        OP_SWAP_MEM     = 4'h4
    } op_t;
    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b001,
        ST_READ  = 3'b010,
        ST_WRITE = 3'b100
    } state_t;
endpackage

//--- design/data_mem.sv
// data memory of the slice: one write port, registered read data
// assumes a single clock; read data appear one edge after the address
`timescale 1ns/10ps
`default_nettype none
`include "sub_swap_defines.svh"
module data_mem
#(
    parameter int DEPTH = `MEM_DEPTH
)
(
    // clock
    input  wire logic                        clk,
    // read port
    input  wire logic [`MEM_ADDR_WIDTH-1:0]  readAddr,
    output logic      [`DATA_WIDTH-1:0]      readData,
    // write port
    input  wire logic                        writeEn,
    input  wire logic [`MEM_ADDR_WIDTH-1:0]  writeAddr,
    input  wire logic [`DATA_WIDTH-1:0]      writeData
);
    logic [`DATA_WIDTH-1:0] store [DEPTH];

    always_ff @(posedge clk)
    begin
        if (writeEn)
        begin
            store[writeAddr] <= writeData;
        end
        readData <= store[readAddr];
    end
endmodule
`default_nettype wire

//--- design/subtract_and_swap_alu.sv
// Contract
// RULE1 - memory subtract: working register minus byte into working register, memory kept
// RULE2 - memory-target subtract: working register minus byte written back, register kept
// RULE3 - immediate subtract: working register minus instruction constant into working register
// RULE4 - no-borrow flag 0 when difference negative, 1 when positive or zero
// RULE5 - subtracts update only range, zero, half-borrow and no-borrow flags
// RULE6 - nibble exchange swaps upper and lower four bits of memory byte
// RULE7 - exchanged byte written back; working register and flags unchanged
//
// subtract and nibble exchange slice with its own data memory
// assumes the decoder holds opStart for one cycle and waits for opDone
// memory contents are not reset; preload them before use
`timescale 1ns/10ps
`default_nettype none
`include "sub_swap_defines.svh"
module subtract_and_swap_alu
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // instruction request
    input  wire logic                   opStart,
    input  wire sub_swap_pkg::op_t      opCode,
    input  wire sub_swap_pkg::addr_t    opAddr,
    input  wire sub_swap_pkg::byte_t    opImm,
    output logic                        opBusy,
    output logic                        opDone,
    // memory preload port, used while idle
    input  wire logic                   loadEn,
    input  wire sub_swap_pkg::addr_t    loadAddr,
    input  wire sub_swap_pkg::byte_t    loadData,
    // memory byte at the latched operand address, read again every cycle
    output sub_swap_pkg::byte_t         memData,
    // architectural state
    output sub_swap_pkg::byte_t         workingRegister,
    output sub_swap_pkg::flags_t        statusFlags
);
    import sub_swap_pkg::*;

    // ====================================================
    // state
    state_t state_r;
    state_t state_nxt;
    op_t    op_r;
    op_t    op_nxt;
    addr_t  addr_r;
    addr_t  addr_nxt;
    byte_t  imm_r;
    byte_t  imm_nxt;
    byte_t  work_r;
    byte_t  work_nxt;
    flags_t flags_r;
    flags_t flags_nxt;
    logic   done_r;
    logic   done_nxt;

    // ====================================================
    // memory
    byte_t  rdData;
    logic   memWe;
    addr_t  memWaddr;
    byte_t  memWdata;
    addr_t  memRaddr;

    data_mem #(.DEPTH(`MEM_DEPTH)) u_mem
    (
        .clk       (clk),
        .readAddr  (memRaddr),
        .readData  (rdData),
        .writeEn   (memWe),
        .writeAddr (memWaddr),
        .writeData (memWdata)
    );

    // ====================================================
    // subtractor
    byte_t                subtrahend;
    logic [`DATA_WIDTH:0] diffWide;
    logic [`NIBBLE_WIDTH:0] lowWide;
    byte_t                diff;
    flags_t               subFlags;
    byte_t                swapped;
    logic                 signsDiffer;
    logic                 signFlipped;

    always_comb
    begin
        subtrahend = (op_r == OP_SUB_IMM) ? imm_r : rdData;
        diffWide   = {1'b0, work_r} - {1'b0, subtrahend};
        lowWide    = {1'b0, work_r[`NIBBLE_WIDTH-1:0]} - {1'b0, subtrahend[`NIBBLE_WIDTH-1:0]};
        diff       = diffWide[`DATA_WIDTH-1:0];
        subFlags   = `FLAG_RESET;
        // borrow out of bit 7 means the unsigned difference went negative
        subFlags[`FLAG_NOBORROW] = ~diffWide[`DATA_WIDTH]; // RULE4
        // borrow out of bit 3 sets the half-borrow flag
        subFlags[`FLAG_HALF]     = lowWide[`NIBBLE_WIDTH];
        subFlags[`FLAG_ZERO]     = (diff == 8'h00);
        // signed overflow needs operands of opposite sign and a result sign flip
        signsDiffer = (work_r[`DATA_WIDTH-1] != subtrahend[`DATA_WIDTH-1]);
        signFlipped = (diff[`DATA_WIDTH-1] != work_r[`DATA_WIDTH-1]);
        subFlags[`FLAG_RANGE]    = signsDiffer && signFlipped;
        swapped = {rdData[`NIBBLE_WIDTH-1:0], rdData[`DATA_WIDTH-1:`NIBBLE_WIDTH]}; // RULE6
    end

    // ====================================================
    // sequencer
    always_comb
    begin
        state_nxt = state_r;
        op_nxt    = op_r;
        addr_nxt  = addr_r;
        imm_nxt   = imm_r;
        work_nxt  = work_r;
        flags_nxt = flags_r;
        done_nxt  = 1'b0;
        memWe     = 1'b0;
        memWaddr  = loadAddr;
        memWdata  = loadData;
        // hold the latched address so memData keeps showing the operand
        memRaddr  = addr_r;
        unique case (state_r)
            ST_IDLE:
            begin
                // preload shares the write port, so it is honoured only while idle
                memWe = loadEn;
                if (opStart)
                begin
                    op_nxt   = opCode;
                    addr_nxt = opAddr;
                    imm_nxt  = opImm;
                    memRaddr = opAddr;
                    // immediate form needs no memory read
                    if (opCode == OP_SUB_IMM)
                    begin
                        state_nxt = ST_WRITE;
                    end
                    // the idle code only reads, so it completes at once
                    else if (opCode == OP_NONE)
                    begin
                        done_nxt = 1'b1;
                    end
                    else
                    begin
                        state_nxt = ST_READ;
                    end
                end
            end
            ST_READ:
            begin
                // read data from the idle edge are valid now
                state_nxt = ST_WRITE;
            end
            ST_WRITE:
            begin
                state_nxt = ST_IDLE;
                done_nxt  = 1'b1;
                memWaddr  = addr_r;
                case (op_r)
                    OP_SUB_TO_WORK, OP_SUB_IMM:
                    begin
                        work_nxt  = diff; // RULE1 RULE3
                        flags_nxt = subFlags; // RULE5
                    end
                    OP_SUB_TO_MEM:
                    begin
                        memWe     = 1'b1;
                        memWdata  = diff; // RULE2
                        flags_nxt = subFlags; // RULE5
                    end
                    OP_SWAP_MEM:
                    begin
                        memWe    = 1'b1;
                        memWdata = swapped; // RULE7
                    end
                    // unknown codes finish with no write and no flag change
                    default:
                    begin
                        memWe = 1'b0;
                    end
                endcase
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ====================================================
    // registers
    // reset clears the sequencer and architectural registers; the memory keeps its contents
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= ST_IDLE;
            op_r    <= OP_NONE;
            addr_r  <= '0;
            imm_r   <= `WORK_RESET;
            work_r  <= `WORK_RESET;
            flags_r <= `FLAG_RESET;
            done_r  <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            op_r    <= op_nxt;
            addr_r  <= addr_nxt;
            imm_r   <= imm_nxt;
            work_r  <= work_nxt;
            flags_r <= flags_nxt;
            done_r  <= done_nxt;
        end
    end

    // ====================================================
    // outputs
    // busy is decoded from the state register; done has its own flop
    assign opBusy          = (state_r != ST_IDLE);
    assign opDone          = done_r;
    assign memData         = rdData;
    assign workingRegister = work_r;
    assign statusFlags     = flags_r;
endmodule
`default_nettype wire

//--- bench/subtract_and_swap_alu_props.sv
// assertions for the subtract and nibble exchange slice
// sees only the top module ports; bound after the module
`timescale 1ns/10ps
`default_nettype none
module sub_swap_checker
(
    // watched ports
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  opStart,
    input wire logic                  opBusy,
    input wire logic                  opDone,
    input wire sub_swap_pkg::op_t     opCode,
    input wire sub_swap_pkg::byte_t   opImm,
    input wire sub_swap_pkg::byte_t   memData,
    input wire sub_swap_pkg::byte_t   workingRegister,
    input wire sub_swap_pkg::flags_t  statusFlags
);
    import sub_swap_pkg::*;
    logic take;
    assign take = opStart && !opBusy;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_sub_work_result: assert property (take && opCode == OP_SUB_TO_WORK |-> ##3
        opDone && workingRegister == $past(workingRegister, 3) - $past(memData, 2))
        else $error("sub to work wrong");
    a_sub_mem_keep: assert property (take && opCode == OP_SUB_TO_MEM |-> ##3
        opDone && $stable(workingRegister)) else $error("sub to mem touched work");
    a_imm_result: assert property (take && opCode == OP_SUB_IMM |-> ##2
        opDone && workingRegister == $past(workingRegister, 2) - $past(opImm, 2))
        else $error("imm sub wrong");
    a_imm_busy_span: assert property (take && opCode == OP_SUB_IMM |=>
        opBusy ##1 !opBusy) else $error("imm busy span");
    a_noborrow_imm: assert property (take && opCode == OP_SUB_IMM |-> ##2
        statusFlags[0] == ($past(workingRegister, 2) >= $past(opImm, 2)))
        else $error("no-borrow wrong");
    a_half_zero: assert property (take && opCode == OP_SUB_IMM |-> ##2
        statusFlags[1] == ($past(workingRegister[3:0], 2) < $past(opImm[3:0], 2))
        && statusFlags[2] == ($past(workingRegister, 2) == $past(opImm, 2)))
        else $error("half or zero wrong");
    // flags may only move at completion, never between operations
    a_flag_hold: assert property ($changed(statusFlags) |-> opDone)
        else $error("flags moved idle");
    a_swap_keep: assert property (take && opCode == OP_SWAP_MEM |-> ##3
        opDone && $stable(workingRegister) && $stable(statusFlags))
        else $error("swap touched state");
    cover property (take && opCode == OP_SUB_TO_WORK);
    cover property (take && opCode == OP_SUB_TO_MEM);
    cover property (take && opCode == OP_SWAP_MEM);
endmodule
bind subtract_and_swap_alu sub_swap_checker chk_u (.clk, .rst, .opStart, .opBusy, .opDone,
    .opCode, .opImm, .memData, .workingRegister, .statusFlags);
`default_nettype wire

//--- bench/subtract_and_swap_alu_bench.sv
// self-checking bench for the subtract and nibble exchange slice
// inputs move on the falling edge; memory read back through the idle opcode
`timescale 1ns/10ps
`default_nettype none
`include "sub_swap_defines.svh"
module subtract_and_swap_alu_bench;
    import sub_swap_pkg::*;
    logic   clk, rst, opStart, loadEn, opBusy, opDone;
    op_t    opCode;
    addr_t  opAddr, loadAddr;
    byte_t  opImm, loadData, memData, workingRegister, w, e;
    flags_t statusFlags, f;
    int     err_total, checks, i;
    byte_t  imms [4] = '{8'h01, 8'hFF, 8'h80, 8'h00};
    subtract_and_swap_alu dut_u (.clk, .rst, .opStart, .opCode, .opAddr, .opImm, .opBusy,
        .opDone, .loadEn, .loadAddr, .loadData, .memData, .workingRegister, .statusFlags);
    always #25 clk = ~clk;
    task automatic chk(input logic [7:0] s, input logic [7:0] x);
        checks++;
        if (s !== x)
        begin
            err_total++;
            $display("[ERR] %0t seen %h exp %h", $time, s, x);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    function automatic flags_t fl(input byte_t a, input byte_t b);
        byte_t d;
        d = a - b;
        return {a[7] != b[7] && d[7] != a[7], d == 8'h00, a[3:0] < b[3:0], a >= b};
    endfunction
    // bounded wait: a hung slice ends the run as a failure
    task automatic op(input op_t c, input byte_t a, input byte_t x);
        int n;
        int lat;
        // negedges from take to done: idle code 0, immediate 1, all others 2
        lat = (c == OP_NONE) ? 0 : ((c == OP_SUB_IMM) ? 1 : 2);
        @(negedge clk);
        // done of the previous operation must have stood one cycle only
        chk({7'h0, opDone}, 8'h00);
        opStart = 1'h1;
        opCode  = c;
        opAddr  = a;
        opImm   = x;
        @(negedge clk);
        opStart = 1'h0;
        chk({7'h0, opBusy}, {7'h0, c != OP_NONE});
        for (n = 0; opDone !== 1'h1; n++)
        begin
            if (n == 20)
            begin
                err_total++;
                final_report();
            end
            @(negedge clk);
        end
        chk(n[7:0], lat[7:0]);
        chk({7'h0, opBusy}, 8'h00);
    endtask
    task automatic load(input byte_t a, input byte_t d);
        @(negedge clk);
        {loadEn, loadAddr, loadData} = {1'h1, a, d};
        @(negedge clk);
        loadEn = 1'h0;
    endtask
    task automatic s_reset;
        rst = 1'h1;
        repeat (10) @(negedge clk);
        chk(workingRegister, `WORK_RESET);
        chk({4'h0, statusFlags}, {4'h0, `FLAG_RESET});
        chk({6'h0, opBusy, opDone}, 8'h00);
        rst = 1'h0;
        w = `WORK_RESET;
    endtask
    // walks through borrow with half-borrow, zero, overflow, then a plain no-borrow step in turn
    task automatic s_imm;
        for (i = 0; i < 4; i++)
        begin
            f = fl(w, imms[i]);
            w = w - imms[i];
            op(OP_SUB_IMM, 8'h00, imms[i]);
            chk(workingRegister, w);
            chk({4'h0, statusFlags}, {4'h0, f});
        end
    endtask
    task automatic s_sub_work;
        load(8'h10, 8'h35);
        f = fl(w, 8'h35);
        w = w - 8'h35;
        op(OP_SUB_TO_WORK, 8'h10, 8'h00);
        chk(workingRegister, w);
        chk({4'h0, statusFlags}, {4'h0, f});
        op(OP_NONE, 8'h10, 8'h00);
        chk(memData, 8'h35);
    endtask
    task automatic s_sub_mem;
        load(8'h11, 8'hC4);
        f = fl(w, 8'hC4);
        e = w - 8'hC4;
        op(OP_SUB_TO_MEM, 8'h11, 8'h00);
        chk(workingRegister, w);
        chk({4'h0, statusFlags}, {4'h0, f});
        op(OP_NONE, 8'h11, 8'h00);
        chk(memData, e);
    endtask
    task automatic s_swap;
        load(8'h12, 8'hA5);
        op(OP_SWAP_MEM, 8'h12, 8'h00);
        chk(workingRegister, w);
        chk({4'h0, statusFlags}, {4'h0, f});
        op(OP_NONE, 8'h12, 8'h00);
        chk(memData, 8'h5A);
        // an undefined code must complete and leave every piece of state alone
        op(op_t'(4'hF), 8'h12, 8'h00);
        chk(workingRegister, w);
        chk({4'h0, statusFlags}, {4'h0, f});
        op(OP_NONE, 8'h12, 8'h00);
        chk(memData, 8'h5A);
    endtask
    initial
    begin
        {clk, opStart, loadEn, opAddr, opImm, loadAddr, loadData} = '0;
        opCode = OP_NONE;
        err_total = 0;
        checks = 0;
        s_reset();
        s_imm();
        s_sub_work();
        s_sub_mem();
        s_swap();
        s_reset();
        // the slice must work again straight after a mid-run reset
        s_imm();
        final_report();
    end
endmodule
`default_nettype wire
